// [hdl/cmp_branch_pkg.sv]
// Constants and types shared by the compare, skip and branch unit
package cmp_branch_pkg;

  // Datapath widths
  localparam int PC_W = 16;
  localparam int DATA_W = 8;
  localparam int OFFS_W = 7;
  localparam int SEL_W = 3;

  // Bit positions inside the status flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Program counter steps, in words
  localparam logic [PC_W-1:0] PC_STEP_ONE = 16'h0001;
  localparam logic [PC_W-1:0] SKIP_ONE_WORD = 16'h0002;
  localparam logic [PC_W-1:0] SKIP_TWO_WORD = 16'h0003;

  // Extra cycles beyond the first one
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_ONE = 2'h1;
  localparam logic [1:0] WAIT_TWO = 2'h2;

  // Reset values
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;

  typedef enum logic [4:0] {
    compare_op                 = 5'h00,
    compare_with_carry_op      = 5'h01,
    compare_immediate_op       = 5'h02,
    equal_skip_op              = 5'h03,
    reg_bit_clear_skip_op      = 5'h04,
    reg_bit_set_skip_op        = 5'h05,
    io_bit_clear_skip_op       = 5'h06,
    io_bit_set_skip_op         = 5'h07,
    flag_set_branch_op         = 5'h08,
    flag_clear_branch_op       = 5'h09,
    equal_branch_op            = 5'h0A,
    not_equal_branch_op        = 5'h0B,
    carry_set_branch_op        = 5'h0C,
    carry_clear_branch_op      = 5'h0D,
    same_or_higher_branch_op   = 5'h0E,
    lower_branch_op            = 5'h0F,
    minus_branch_op            = 5'h10,
    plus_branch_op             = 5'h11,
    signed_ge_branch_op        = 5'h12,
    signed_lt_branch_op        = 5'h13,
    half_carry_set_branch_op   = 5'h14,
    half_carry_clear_branch_op = 5'h15,
    transfer_set_branch_op     = 5'h16,
    transfer_clear_branch_op   = 5'h17,
    overflow_set_branch_op     = 5'h18,
    overflow_clear_branch_op   = 5'h19
  } op_t;

  typedef enum logic [1:0] {
    CLASS_NONE   = 2'h0,
    CLASS_CMP    = 2'h1,
    CLASS_SKIP   = 2'h2,
    CLASS_BRANCH = 2'h3
  } op_class_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } seq_state_t;

endpackage : cmp_branch_pkg

// [hdl/cmp_flags.sv]
// Subtract-and-compare flag generator, no result is stored
`timescale 1ns/10ps
`default_nettype none
module cmp_flags #(
  parameter int W = 8
) (
  input wire logic [W-1:0] lhs,
  input wire logic [W-1:0] rhs,
  input wire logic carry_in,
  output logic half_out,
  output logic carry_out,
  output logic ovf_out,
  output logic neg_out,
  output logic zero_out
);

  localparam int HB = W / 2 - 1;

  logic [W-1:0] diff;

  // Difference only feeds the flags; it never reaches a register file
  assign diff = lhs - rhs - {{(W-1){1'b0}}, carry_in};

  // Borrow out of the low nibble and out of the top bit
  assign half_out = (~lhs[HB] & rhs[HB]) | (rhs[HB] & diff[HB])
                  | (diff[HB] & ~lhs[HB]);
  assign carry_out = (~lhs[W-1] & rhs[W-1]) | (rhs[W-1] & diff[W-1])
                   | (diff[W-1] & ~lhs[W-1]);
  // Signed overflow when operand signs differ and result sign flips
  assign ovf_out = (lhs[W-1] & ~rhs[W-1] & ~diff[W-1])
                 | (~lhs[W-1] & rhs[W-1] & diff[W-1]);
  assign neg_out = diff[W-1];
  assign zero_out = (diff == '0);

endmodule : cmp_flags
`default_nettype wire

// [hdl/cmp_branch_unit.sv]
// Compare, conditional skip and conditional branch execution unit
`timescale 1ns/10ps
`default_nettype none
module cmp_branch_unit
  import cmp_branch_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic op_start,
  input wire op_t op_code,
  input wire logic [DATA_W-1:0] operand_a,
  input wire logic [DATA_W-1:0] operand_b,
  input wire logic [SEL_W-1:0] bit_sel,
  input wire logic [SEL_W-1:0] flag_sel,
  input wire logic [OFFS_W-1:0] branch_offset,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [DATA_W-1:0] status_in,
  input wire logic next_is_two_word,
  output logic busy,
  output logic op_done,
  output logic pc_load,
  output logic [PC_W-1:0] pc_next,
  output logic status_write,
  output logic [DATA_W-1:0] status_out,
  output logic cond_taken
);

  seq_state_t state_reg, state_next;
  logic [1:0] wait_reg, wait_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic pc_load_reg, pc_load_next;
  logic [PC_W-1:0] pc_reg, pc_next_val;
  logic status_write_reg, status_write_next;
  logic [DATA_W-1:0] status_reg, status_next;
  logic taken_reg, taken_next;

  logic accept;
  op_class_t op_class;
  logic cond_true;
  logic with_carry;
  logic [PC_W-1:0] seq_pc, branch_pc, skip_pc;
  logic [DATA_W-1:0] cmp_rhs_carry_flags;
  logic f_half, f_carry, f_ovf, f_neg, f_zero;
  logic reg_bit, sel_flag;

  // A new operation is taken only while the sequencer is idle
  assign accept = op_start && (state_reg == ST_IDLE);
  assign reg_bit = operand_a[bit_sel];
  assign sel_flag = status_in[flag_sel];

  assign seq_pc = pc_in + PC_STEP_ONE;
  assign branch_pc = seq_pc
                   + {{(PC_W-OFFS_W){branch_offset[OFFS_W-1]}}, branch_offset};
  assign skip_pc = next_is_two_word ? pc_in + SKIP_TWO_WORD
                                    : pc_in + SKIP_ONE_WORD;

  cmp_flags #(
    .W(DATA_W)
  ) u_cmp_flags (
    .lhs(operand_a),
    .rhs(operand_b),
    .carry_in(with_carry & status_in[FLAG_C]),
    .half_out(f_half),
    .carry_out(f_carry),
    .ovf_out(f_ovf),
    .neg_out(f_neg),
    .zero_out(f_zero)
  );

  // Flags after a compare; S, T and I pass through untouched
  always_comb begin
    cmp_rhs_carry_flags = status_in;
    cmp_rhs_carry_flags[FLAG_C] = f_carry;
    cmp_rhs_carry_flags[FLAG_Z] = f_zero;
    cmp_rhs_carry_flags[FLAG_N] = f_neg;
    cmp_rhs_carry_flags[FLAG_V] = f_ovf;
    cmp_rhs_carry_flags[FLAG_H] = f_half;
  end

  // Operation decode: class and test condition
  always_comb begin
    // Branch class unless an item below says otherwise
    op_class = CLASS_BRANCH;
    cond_true = 1'b0;
    with_carry = 1'b0;
    case (op_code)
      compare_op, compare_immediate_op: begin
        op_class = CLASS_CMP;
      end
      compare_with_carry_op: begin
        op_class = CLASS_CMP;
        with_carry = 1'b1;
      end
      equal_skip_op: begin
        op_class = CLASS_SKIP;
        cond_true = (operand_a == operand_b);
      end
      reg_bit_clear_skip_op: begin
        op_class = CLASS_SKIP;
        cond_true = ~reg_bit;
      end
      reg_bit_set_skip_op: begin
        op_class = CLASS_SKIP;
        cond_true = reg_bit;
      end
      // I/O bit clear skip; operand_a carries the port value
      io_bit_clear_skip_op: begin
        op_class = CLASS_SKIP;
        cond_true = ~reg_bit;
      end
      io_bit_set_skip_op: begin
        op_class = CLASS_SKIP;
        cond_true = reg_bit;
      end
      flag_set_branch_op: cond_true = sel_flag;
      flag_clear_branch_op: cond_true = ~sel_flag;
      equal_branch_op: cond_true = status_in[FLAG_Z];
      not_equal_branch_op: cond_true = ~status_in[FLAG_Z];
      // carry branches, aliases share one test
      carry_set_branch_op, lower_branch_op: cond_true = status_in[FLAG_C];
      carry_clear_branch_op, same_or_higher_branch_op:
        cond_true = ~status_in[FLAG_C];
      minus_branch_op: cond_true = status_in[FLAG_N];
      plus_branch_op: cond_true = ~status_in[FLAG_N];
      signed_ge_branch_op:
        cond_true = ~(status_in[FLAG_N] ^ status_in[FLAG_V]);
      signed_lt_branch_op:
        cond_true = status_in[FLAG_N] ^ status_in[FLAG_V];
      half_carry_set_branch_op: cond_true = status_in[FLAG_H];
      half_carry_clear_branch_op: cond_true = ~status_in[FLAG_H];
      transfer_set_branch_op: cond_true = status_in[FLAG_T];
      transfer_clear_branch_op: cond_true = ~status_in[FLAG_T];
      overflow_set_branch_op: cond_true = status_in[FLAG_V];
      overflow_clear_branch_op: cond_true = ~status_in[FLAG_V];
      // Unused codes retire as a plain one-cycle step
      default: begin
        op_class = CLASS_NONE;
      end
    endcase
  end

  // Sequencer next state; results stand until the next accepted op
  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    done_next = 1'b0;
    pc_load_next = 1'b0;
    pc_next_val = pc_reg;
    status_write_next = 1'b0;
    status_next = status_reg;
    taken_next = taken_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (op_start) begin
          pc_next_val = seq_pc;
          wait_next = WAIT_NONE;
          taken_next = 1'b0;
          unique case (op_class)
            CLASS_CMP: begin
              status_write_next = 1'b1;
              status_next = cmp_rhs_carry_flags;
            end
            // one extra cycle per skipped word
            CLASS_SKIP: begin
              taken_next = cond_true;
              if (cond_true) begin
                pc_next_val = skip_pc;
                wait_next = next_is_two_word ? WAIT_TWO : WAIT_ONE;
              end
            end
            // taken branch costs one extra cycle
            CLASS_BRANCH: begin
              taken_next = cond_true;
              if (cond_true) begin
                pc_next_val = branch_pc;
                wait_next = WAIT_ONE;
              end
            end
            CLASS_NONE: begin
              pc_next_val = seq_pc;
            end
          endcase
          if (wait_next == WAIT_NONE) begin
            done_next = 1'b1;
            pc_load_next = 1'b1;
          end else begin
            state_next = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        wait_next = wait_reg - WAIT_ONE;
        if (wait_reg == WAIT_ONE) begin
          done_next = 1'b1;
          pc_load_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
    endcase
    busy_next = (state_next == ST_WAIT);
  end

  // Sequencer registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      wait_reg <= WAIT_NONE;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      pc_reg <= PC_RST;
      status_write_reg <= 1'b0;
      status_reg <= STATUS_RST;
      taken_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      pc_load_reg <= pc_load_next;
      pc_reg <= pc_next_val;
      status_write_reg <= status_write_next;
      status_reg <= status_next;
      taken_reg <= taken_next;
    end
  end

  assign busy = busy_reg;
  assign op_done = done_reg;
  assign pc_load = pc_load_reg;
  assign pc_next = pc_reg;
  assign status_write = status_write_reg;
  assign status_out = status_reg;
  assign cond_taken = taken_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_cmp_one_cycle: assert property (
    accept && op_class == CLASS_CMP |=> op_done && status_write && !busy)
    else $error("compare did not finish in one cycle");
  a_cmp_zero_carry: assert property (
    accept && op_code == compare_op |=>
      status_out[FLAG_Z] == ($past(operand_a) == $past(operand_b)) &&
      status_out[FLAG_C] == ($past(operand_a) < $past(operand_b)))
    else $error("compare zero or carry flag wrong");
  a_skip_one_word: assert property (
    accept && op_class == CLASS_SKIP && cond_true && !next_is_two_word
      |=> busy && !op_done ##1 op_done && pc_load &&
      pc_next == $past(pc_in, 2) + SKIP_ONE_WORD)
    else $error("one-word skip wrong");
  a_skip_two_word: assert property (
    accept && op_class == CLASS_SKIP && cond_true && next_is_two_word
      |=> (busy && !op_done)[*2] ##1 op_done &&
      pc_next == $past(pc_in, 3) + SKIP_TWO_WORD)
    else $error("two-word skip wrong");
  // Back-to-back ops are legal, so only the extra cycles are watched
  a_skip_no_flags: assert property (
    accept && op_class == CLASS_SKIP |=> !status_write)
    else $error("skip wrote flags");
  a_busy_flags_kept: assert property (
    busy |-> !status_write && $stable(status_out))
    else $error("flags changed during extra cycles");
  a_equal_skip_cond: assert property (
    accept && op_code == equal_skip_op |=>
      cond_taken == ($past(operand_a) == $past(operand_b)))
    else $error("equality skip decision wrong");
  a_branch_taken: assert property (
    accept && op_class == CLASS_BRANCH && cond_true
      |=> busy && !pc_load ##1 op_done && pc_next == $past(pc_in, 2)
      + PC_STEP_ONE + PC_W'(signed'($past(branch_offset, 2))))
    else $error("taken branch target or timing wrong");
  a_branch_not_taken: assert property (
    accept && op_class == CLASS_BRANCH && !cond_true |=>
      op_done && !busy && !cond_taken &&
      pc_next == $past(pc_in) + PC_STEP_ONE)
    else $error("untaken branch wrong");
  a_signed_ge_test: assert property (
    accept && op_code == signed_ge_branch_op |=>
      cond_taken == !($past(status_in[FLAG_N]) ^ $past(status_in[FLAG_V])))
    else $error("signed ge decision wrong");
  a_signed_lt_test: assert property (
    accept && op_code == signed_lt_branch_op |=>
      cond_taken == ($past(status_in[FLAG_N]) ^ $past(status_in[FLAG_V])))
    else $error("signed lt decision wrong");

  c_cmp_done: cover property (accept && op_class == CLASS_CMP);
  c_two_word_skip: cover property (
    accept && op_class == CLASS_SKIP && cond_true && next_is_two_word);
  c_back_branch: cover property (
    accept && op_class == CLASS_BRANCH && cond_true &&
    branch_offset[OFFS_W-1]);

endmodule : cmp_branch_unit
`default_nettype wire

// [tb/cmp_branch_unit_tb.sv]
// Self-checking bench for the compare, skip and branch unit
`timescale 1ns/10ps
`default_nettype none
module cmp_branch_unit_tb
  import cmp_branch_pkg::*;
;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic op_start = 1'h0;
  op_t op_code = compare_op;
  logic [DATA_W-1:0] operand_a = 8'h00;
  logic [DATA_W-1:0] operand_b = 8'h00;
  logic [SEL_W-1:0] bit_sel = 3'h0;
  logic [SEL_W-1:0] flag_sel = 3'h0;
  logic [OFFS_W-1:0] branch_offset = 7'h00;
  logic [PC_W-1:0] pc_in = 16'h0000;
  logic [DATA_W-1:0] status_in = 8'h00;
  logic next_is_two_word = 1'h0;
  logic busy;
  logic op_done;
  logic pc_load;
  logic [PC_W-1:0] pc_next;
  logic status_write;
  logic [DATA_W-1:0] status_out;
  logic cond_taken;
  int failures = 0;
  int num_checks = 0;
  logic [DATA_W-1:0] last_status = STATUS_RST;

  cmp_branch_unit cmp_branch_unit_inst (
    .clk_sys(clk_sys), .rst(rst), .op_start(op_start), .op_code(op_code),
    .operand_a(operand_a), .operand_b(operand_b), .bit_sel(bit_sel),
    .flag_sel(flag_sel), .branch_offset(branch_offset), .pc_in(pc_in),
    .status_in(status_in), .next_is_two_word(next_is_two_word),
    .busy(busy), .op_done(op_done), .pc_load(pc_load), .pc_next(pc_next),
    .status_write(status_write), .status_out(status_out),
    .cond_taken(cond_taken)
  );

  // 25 MHz core clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp,
      input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : check_val

  task automatic check_bit(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %b want %b", $time, msg, got, exp);
    end
  endtask : check_bit

  // Flags of a subtract, borrow taken from the ninth bit
  function automatic logic [7:0] exp_flags(op_t op, logic [7:0] a,
      logic [7:0] b, logic [7:0] st);
    logic cin;
    logic [8:0] r;
    logic [7:0] f;
    cin = (op == compare_with_carry_op) ? st[FLAG_C] : 1'h0;
    r = {1'h0, a} - {1'h0, b} - {8'h00, cin};
    f = st;
    f[FLAG_C] = r[8];
    f[FLAG_Z] = (r[7:0] == 8'h00);
    f[FLAG_N] = r[7];
    f[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    return f;
  endfunction : exp_flags

  // Condition of every skip and branch, unknown codes never taken
  function automatic logic exp_taken(op_t op, logic [7:0] a, logic [7:0] b,
      logic [2:0] bs, logic [2:0] fs, logic [7:0] st);
    case (op)
      equal_skip_op: return a == b;
      reg_bit_clear_skip_op, io_bit_clear_skip_op: return !a[bs];
      reg_bit_set_skip_op, io_bit_set_skip_op: return a[bs];
      flag_set_branch_op: return st[fs];
      flag_clear_branch_op: return !st[fs];
      equal_branch_op: return st[FLAG_Z];
      not_equal_branch_op: return !st[FLAG_Z];
      carry_set_branch_op, lower_branch_op: return st[FLAG_C];
      carry_clear_branch_op, same_or_higher_branch_op: return !st[FLAG_C];
      minus_branch_op: return st[FLAG_N];
      plus_branch_op: return !st[FLAG_N];
      signed_ge_branch_op: return !(st[FLAG_N] ^ st[FLAG_V]);
      signed_lt_branch_op: return st[FLAG_N] ^ st[FLAG_V];
      half_carry_set_branch_op: return st[FLAG_H];
      half_carry_clear_branch_op: return !st[FLAG_H];
      transfer_set_branch_op: return st[FLAG_T];
      transfer_clear_branch_op: return !st[FLAG_T];
      overflow_set_branch_op: return st[FLAG_V];
      overflow_clear_branch_op: return !st[FLAG_V];
      default: return 1'h0;
    endcase
  endfunction : exp_taken

  // One request; hold keeps op_start up as a compare for the first busy cycle
  task automatic run_op(input op_t op, input logic [7:0] a,
      input logic [7:0] b, input logic [2:0] bs, input logic [2:0] fs,
      input logic [6:0] k, input logic [15:0] pc, input logic [7:0] st,
      input logic two, input logic hold, output int cyc, output logic sw,
      output logic pl);
    logic done;
    @(negedge clk_sys);
    op_code = op;
    operand_a = a;
    operand_b = b;
    bit_sel = bs;
    flag_sel = fs;
    branch_offset = k;
    pc_in = pc;
    status_in = st;
    next_is_two_word = two;
    op_start = 1'h1;
    cyc = 0;
    done = 1'h0;
    sw = 1'h0;
    pl = 1'h0;
    while (!done) begin
      if (cyc == 8) begin
        failures++;
        $display("wrong value at %0t: operation never completed", $time);
        finish_test;
      end
      @(posedge clk_sys);
      #1;
      cyc++;
      done = (op_done === 1'h1);
      check_bit(busy, !done, "busy");
      pl = (pc_load === 1'h1);
      if (status_write === 1'h1) sw = 1'h1;
      if (cyc == 1 || (hold && cyc == 2)) begin
        @(negedge clk_sys);
        if (hold && cyc == 1) op_code = compare_op;
        else op_start = 1'h0;
      end
    end
  endtask : run_op

  task automatic do_cmp(input op_t op, input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] st);
    int cyc;
    logic sw;
    logic pl;
    run_op(op, a, b, 3'h0, 3'h0, 7'h00, 16'h0040, st, 1'h0, 1'h0, cyc, sw, pl);
    last_status = exp_flags(op, a, b, st);
    check_val({8'h00, status_out}, {8'h00, last_status}, "flags");
    check_bit(sw, 1'h1, "flag write");
    check_val(pc_next, 16'h0041, "next pc");
    check_val(16'(cyc), 16'h0001, "cycles");
  endtask : do_cmp

  // Skip or branch: target, duration, and flags left alone
  task automatic do_cond(input op_t op, input logic [7:0] a,
      input logic [7:0] b, input logic [2:0] bs, input logic [2:0] fs,
      input logic [6:0] k, input logic [15:0] pc, input logic [7:0] st,
      input logic two, input logic hold);
    int cyc;
    int ecyc;
    logic sw;
    logic pl;
    logic tk;
    logic skip;
    logic [15:0] epc;
    tk = exp_taken(op, a, b, bs, fs, st);
    skip = (op >= equal_skip_op) && (op <= io_bit_set_skip_op);
    epc = pc + PC_STEP_ONE;
    ecyc = 1;
    if (tk && skip) begin
      epc = pc + (two ? SKIP_TWO_WORD : SKIP_ONE_WORD);
      ecyc = two ? 3 : 2;
    end else if (tk) begin
      epc = pc + PC_STEP_ONE + {{9{k[6]}}, k};
      ecyc = 2;
    end
    run_op(op, a, b, bs, fs, k, pc, st, two, hold, cyc, sw, pl);
    check_val(pc_next, epc, "target");
    check_val(16'(cyc), 16'(ecyc), "cycles");
    check_bit(cond_taken, tk, "taken");
    check_bit(pl, 1'h1, "pc load");
    check_bit(sw, 1'h0, "flag write");
    check_val({8'h00, status_out}, {8'h00, last_status}, "flags kept");
  endtask : do_cond

  task automatic compare_test;
    do_cmp(compare_op, 8'h10, 8'h10, 8'h00);
    do_cmp(compare_op, 8'h00, 8'h01, 8'h00);
    do_cmp(compare_op, 8'h80, 8'h01, 8'h00);
    do_cmp(compare_with_carry_op, 8'h05, 8'h04, 8'h01);
    do_cmp(compare_with_carry_op, 8'h05, 8'h04, 8'h02);
    do_cmp(compare_immediate_op, 8'h7F, 8'hFF, 8'hF0);
  endtask : compare_test

  // Every bit position, one- and two-word followers mixed
  task automatic skip_test;
    for (int i = 0; i < 8; i++) begin
      do_cond(reg_bit_clear_skip_op, 8'hA5, 8'h00, 3'(i), 3'h0, 7'h00,
        16'h0200, 8'h00, i[0], 1'h0);
      do_cond(reg_bit_set_skip_op, 8'hA5, 8'h00, 3'(i), 3'h0, 7'h00,
        16'h0200, 8'h00, i[1], 1'h0);
      do_cond(io_bit_clear_skip_op, 8'h5A, 8'h00, 3'(i), 3'h0, 7'h00,
        16'hFFFE, 8'h00, i[1], 1'h0);
      do_cond(io_bit_set_skip_op, 8'h5A, 8'h00, 3'(i), 3'h0, 7'h00,
        16'h0300, 8'h00, i[0], 1'h0);
    end
    for (int i = 0; i < 4; i++) begin
      do_cond(equal_skip_op, 8'h3C, 8'h3C ^ 8'(i[1]), 3'h0, 3'h0, 7'h00,
        16'h0400, 8'hFF, i[0], 1'h0);
    end
    do_cond(op_t'(5'h1F), 8'h00, 8'h00, 3'h0, 3'h0, 7'h05, 16'h0010, 8'hFF,
      1'h0, 1'h0);
  endtask : skip_test

  // All branch codes against four flag patterns, both directions
  task automatic branch_test;
    logic [7:0] sts [4] = '{8'h00, 8'hFF, 8'h29, 8'h54};
    for (int o = 8; o < 26; o++) begin
      for (int s = 0; s < 4; s++) begin
        do_cond(op_t'(5'(o)), 8'h00, 8'h00, 3'h0, 3'(o + s),
          s[0] ? 7'h7A : 7'h05, 16'h0003, sts[s], 1'h0,
          1'h0);
      end
    end
  endtask : branch_test

  task automatic reset_test;
    @(posedge clk_sys);
    #1;
    check_val({11'h000, busy, op_done, pc_load, status_write, cond_taken},
      16'h0000, "reset pulses");
    check_val(pc_next, PC_RST, "reset pc");
    check_val({8'h00, status_out}, {8'h00, STATUS_RST}, "reset flags");
  endtask : reset_test

  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'h0;
    reset_test;
    compare_test;
    skip_test;
    branch_test;
    // A compare offered while a two-word skip is busy must be ignored
    do_cond(equal_skip_op, 8'h11, 8'h11, 3'h0, 3'h0, 7'h00, 16'h0100, 8'h00,
      1'h1, 1'h1);
    finish_test;
  end
endmodule : cmp_branch_unit_tb
`default_nettype wire
